// File: pot_host_pkg.sv
package pot_host_pkg;

  // Timing: system clock and target bus bit time
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  // Quarter bit in system cycles, rounded up so the bus never runs fast
  localparam int unsigned QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // Fixed upper address bits of the target
  localparam logic [4:0] ADDR_FIXED = 5'h0B;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_INSTR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // Field positions
  localparam int unsigned CFG_STRAP0_POS = 0;
  localparam int unsigned CFG_STRAP1_POS = 1;
  localparam int unsigned CFG_SHUTDOWN_POS = 2;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned ST_BUSY_POS = 0;
  localparam int unsigned ST_DONE_POS = 1;
  localparam int unsigned ST_NACK_POS = 2;
  localparam int unsigned ST_HELD_POS = 3;
  localparam int unsigned ST_CMDERR_POS = 4;

  // Reset values
  localparam logic [7:0] INSTR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h80;
  localparam logic [7:0] RDATA_RST = 8'h80;

  typedef enum logic [1:0] {
    KIND_WR_INSTR = 2'h0,
    KIND_WR_FULL = 2'h1,
    KIND_WR_MORE = 2'h2,
    KIND_RD = 2'h3
  } kind_t;

  typedef struct packed {
    logic stop_only;
    logic no_stop;
    kind_t kind;
  } cmd_t;

  typedef struct packed {
    logic chan_second;
    logic midscale_reset_bit;
    logic channel_shutdown_bit;
    logic logic_out_first;
    logic logic_out_second;
    logic [2:0] spare;
  } instr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BIT = 4'h4,
    ST_STOP = 4'h8
  } state_t;

  typedef enum logic [3:0] {
    BY_ADDR = 4'h1,
    BY_INSTR = 4'h2,
    BY_DATA = 4'h4,
    BY_READ = 4'h8
  } byte_t;

endpackage

// File: quarter_timer.sv
`timescale 1ns/1ps
module quarter_timer import pot_host_pkg::*; #(
  parameter int unsigned COUNT = QUARTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic hold_i,
  output logic tick_o
);

  localparam int unsigned W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // Count quarters; hold freezes the count while the target stretches the clock
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
    end else if (!hold_i) begin
      if (cnt_q == W'(COUNT - 1)) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// File: byte_shift.sv
`timescale 1ns/1ps
module byte_shift (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [7:0] data_o
);

  logic [7:0] data_q, data_d;

  // Load wins over shift; MSB leaves first
  always_comb begin
    data_d = data_q;
    if (load_i) begin
      data_d = load_val_i;
    end else if (shift_i) begin
      data_d = {data_q[6:0], bit_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_q <= 8'h00;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_o = data_q;

endmodule

// File: pot_host.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Address is 01011 plus two strap bits
// - Start: SDA falls while SCL high
// - Eighth address bit high means read
// - Write sends instruction byte; read does not
// - Instruction MSB selects the channel
// - Nine clocks per byte, MSB first
// - SDA changes only while SCL low
// - Stop: SDA rises while SCL high
// - Read ends with not-acknowledge, then stop
// - New instruction needs fresh address byte
// - Address plus instruction selects readback channel
module pot_host import pot_host_pkg::*; #(
  parameter int unsigned QUARTER = QUARTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic shutdown_pin_n_o
);

  state_t state_q, state_d;
  byte_t byte_q, byte_d;
  cmd_t cmd_q, cmd_d;
  cmd_t new_cmd;
  instr_t instr_q, instr_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] strap_q, strap_d;
  logic shut_q, shut_d;
  logic [7:0] data_q, data_d;
  logic [7:0] rd_q, rd_d;
  logic done_q, done_d;
  logic nack_q, nack_d;
  logic cmderr_q, cmderr_d;
  logic held_q, held_d;
  logic held_wr_q, held_wr_d;
  logic smp_q, smp_d;
  logic scl_oe_n_q, scl_oe_n_d;
  logic sda_oe_n_q, sda_oe_n_d;
  logic lvl_q, lvl_d;
  logic shut_pin_q, shut_pin_d;
  logic [31:0] rdata_q, rdata_d;
  logic tick;
  logic idle;
  logic go;
  logic sh_load;
  logic [7:0] sh_val;
  logic sh_shift;
  logic [7:0] sh_data;
  logic [7:0] instr_byte;

  assign idle = (state_q == ST_IDLE);
  assign go = wr_i && (addr_i == OFS_CMD) && idle;
  assign new_cmd = cmd_t'(wdata_i[CMD_W-1:0]);

  // Instruction byte built from fields; don't-care bits go out as zero
  assign instr_byte = {instr_q.chan_second,
                       instr_q.midscale_reset_bit,
                       instr_q.channel_shutdown_bit,
                       instr_q.logic_out_first,
                       instr_q.logic_out_second,
                       3'h0};

  // Quarter-bit pacing; a target holding SCL low stalls the count
  quarter_timer #(
    .COUNT(QUARTER)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(!idle),
    .hold_i(scl_oe_n_q && !scl_i),
    .tick_o(tick)
  );

  byte_shift u_shift (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(sh_load),
    .load_val_i(sh_val),
    .shift_i(sh_shift),
    .bit_i(smp_q),
    .data_o(sh_data)
  );

  // Software writes, command launch and the bus sequencer
  always_comb begin
    state_d = state_q;
    byte_d = byte_q;
    cmd_d = cmd_q;
    instr_d = instr_q;
    phase_d = phase_q;
    bit_d = bit_q;
    strap_d = strap_q;
    shut_d = shut_q;
    data_d = data_q;
    rd_d = rd_q;
    done_d = done_q;
    nack_d = nack_q;
    cmderr_d = cmderr_q;
    held_d = held_q;
    held_wr_d = held_wr_q;
    smp_d = smp_q;
    scl_oe_n_d = scl_oe_n_q;
    sda_oe_n_d = sda_oe_n_q;
    lvl_d = 1'b0;
    sh_load = 1'b0;
    sh_val = 8'h00;
    sh_shift = 1'b0;

    // Reading status clears done; a completion in that cycle sets it again
    if (rd_i && (addr_i == OFS_STATUS)) begin
      done_d = 1'b0;
    end

    // Instruction and data only change while the sequencer is idle, which includes while a held transfer waits
    if (wr_i) begin
      case (addr_i)
        OFS_CONFIG: begin
          strap_d = {wdata_i[CFG_STRAP1_POS], wdata_i[CFG_STRAP0_POS]};
          shut_d = wdata_i[CFG_SHUTDOWN_POS];
        end
        OFS_INSTR: begin
          if (idle) begin
            instr_d = instr_t'(wdata_i[7:0]);
          end
        end
        OFS_DATA: begin
          if (idle) begin
            data_d = wdata_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Launch; a busy controller ignores a command write
    if (go) begin
      cmd_d = new_cmd;
      nack_d = 1'b0;
      cmderr_d = 1'b0;
      phase_d = 2'h0;
      bit_d = 4'h0;
      if (new_cmd.stop_only) begin
        if (held_q) begin
          state_d = ST_STOP;
          held_d = 1'b0;
          held_wr_d = 1'b0;
        end else begin
          done_d = 1'b1;
        end
      end else if (new_cmd.kind == KIND_WR_MORE) begin
        if (held_wr_q) begin
          state_d = ST_BIT;
          byte_d = BY_DATA;
          sh_load = 1'b1;
          sh_val = data_q;
          held_d = 1'b0;
        end else begin
          cmderr_d = 1'b1;
          done_d = 1'b1;
        end
      end else begin
        // Fresh or repeated start drops whatever was held
        state_d = ST_START;
        byte_d = BY_ADDR;
        sh_load = 1'b1;
        sh_val = {ADDR_FIXED, strap_q[1], strap_q[0], new_cmd.kind == KIND_RD};
        sda_oe_n_d = 1'b1;
        held_d = 1'b0;
        held_wr_d = 1'b0;
      end
    end

    if (tick && !idle) begin
      phase_d = phase_q + 2'h1;
      case (state_q)
        ST_START: begin
          case (phase_q)
            2'h0: scl_oe_n_d = 1'b1; // SDA already high before SCL rises
            2'h1: sda_oe_n_d = 1'b0;
            2'h2: scl_oe_n_d = 1'b0;
            default: begin
              state_d = ST_BIT;
              bit_d = 4'h0;
            end
          endcase
        end
        ST_BIT: begin
          case (phase_q)
            2'h0: begin
              // Data moves only here, with SCL low
              if ((bit_q == 4'h8) || (byte_q == BY_READ)) begin
                sda_oe_n_d = 1'b1;
              end else begin
                sda_oe_n_d = sh_data[7];
              end
            end
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: smp_d = sda_i;
            default: begin
              scl_oe_n_d = 1'b0;
              if (bit_q != 4'h8) begin
                sh_shift = 1'b1;
                bit_d = bit_q + 4'h1;
              end else begin
                bit_d = 4'h0;
                case (byte_q)
                  BY_ADDR: begin
                    if (smp_q) begin
                      nack_d = 1'b1;
                      state_d = ST_STOP;
                    end else if (cmd_q.kind == KIND_RD) begin
                      byte_d = BY_READ;
                    end else begin
                      byte_d = BY_INSTR;
                      sh_load = 1'b1;
                      sh_val = instr_byte;
                    end
                  end
                  BY_INSTR: begin
                    if (smp_q) begin
                      nack_d = 1'b1;
                      state_d = ST_STOP;
                    end else if (cmd_q.kind == KIND_WR_FULL) begin
                      byte_d = BY_DATA;
                      sh_load = 1'b1;
                      sh_val = data_q;
                    end else if (cmd_q.no_stop) begin
                      state_d = ST_IDLE;
                      held_d = 1'b1;
                      held_wr_d = 1'b1;
                      done_d = 1'b1;
                    end else begin
                      state_d = ST_STOP;
                    end
                  end
                  BY_DATA: begin
                    if (smp_q) begin
                      nack_d = 1'b1;
                      state_d = ST_STOP;
                    end else if (cmd_q.no_stop) begin
                      state_d = ST_IDLE;
                      held_d = 1'b1;
                      held_wr_d = 1'b1;
                      done_d = 1'b1;
                    end else begin
                      state_d = ST_STOP;
                    end
                  end
                  default: begin
                    rd_d = sh_data;
                    if (cmd_q.no_stop) begin
                      state_d = ST_IDLE;
                      held_d = 1'b1;
                      done_d = 1'b1;
                    end else begin
                      state_d = ST_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
        ST_STOP: begin
          case (phase_q)
            2'h0: sda_oe_n_d = 1'b0;
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: sda_oe_n_d = 1'b1;
            default: begin
              state_d = ST_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end

    // Pin is low while software asks for shutdown of both channels
    shut_pin_d = !shut_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      byte_q <= BY_ADDR;
      cmd_q <= '0;
      instr_q <= instr_t'(INSTR_RST);
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      strap_q <= 2'h0;
      shut_q <= 1'b0;
      data_q <= DATA_RST;
      rd_q <= RDATA_RST;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      cmderr_q <= 1'b0;
      held_q <= 1'b0;
      held_wr_q <= 1'b0;
      smp_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      lvl_q <= 1'b0;
      shut_pin_q <= 1'b1;
    end else begin
      state_q <= state_d;
      byte_q <= byte_d;
      cmd_q <= cmd_d;
      instr_q <= instr_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      strap_q <= strap_d;
      shut_q <= shut_d;
      data_q <= data_d;
      rd_q <= rd_d;
      done_q <= done_d;
      nack_q <= nack_d;
      cmderr_q <= cmderr_d;
      held_q <= held_d;
      held_wr_q <= held_wr_d;
      smp_q <= smp_d;
      scl_oe_n_q <= scl_oe_n_d;
      sda_oe_n_q <= sda_oe_n_d;
      lvl_q <= lvl_d;
      shut_pin_q <= shut_pin_d;
    end
  end

  // Read mux; data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        OFS_CONFIG: begin
          rdata_d[CFG_STRAP0_POS] = strap_q[0];
          rdata_d[CFG_STRAP1_POS] = strap_q[1];
          rdata_d[CFG_SHUTDOWN_POS] = shut_q;
        end
        OFS_INSTR: rdata_d[7:0] = instr_q;
        OFS_DATA: rdata_d[7:0] = data_q;
        OFS_STATUS: begin
          rdata_d[ST_BUSY_POS] = !idle;
          rdata_d[ST_DONE_POS] = done_q;
          rdata_d[ST_NACK_POS] = nack_q;
          rdata_d[ST_HELD_POS] = held_q;
          rdata_d[ST_CMDERR_POS] = cmderr_q;
        end
        OFS_RDATA: rdata_d[7:0] = rd_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Open-drain pins: only ever pull low, never drive high
  assign scl_o = lvl_q;
  assign sda_o = lvl_q;
  assign scl_oe_n_o = scl_oe_n_q;
  assign sda_oe_n_o = sda_oe_n_q;
  assign shutdown_pin_n_o = shut_pin_q;
  assign rdata_o = rdata_q;

endmodule

// File: pot_host_checker.sv
`timescale 1ns/1ps
module pot_host_checker import pot_host_pkg::*; #(
  parameter int unsigned QUARTER = QUARTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic shutdown_pin_n_o
);
  logic scl_q, sda_q;
  logic [7:0] pulse_q, pulse_d;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // SCL rises since last start; a stop must close whole bytes plus one
  always_comb begin
    pulse_d = pulse_q;
    if (sda_q && !sda_i && scl_i) begin
      pulse_d = 8'h00;
    end else if (scl_i && !scl_q) begin
      pulse_d = pulse_q + 8'h01;
    end
  end
  // Wire levels one cycle back
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pulse_q <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      pulse_q <= pulse_d;
    end
  end
  sequence s_start;
    $fell(sda_i) && scl_i;
  endsequence
  sequence s_first_rise;
    first_match(##[0:400] $rose(scl_i));
  endsequence
  sequence s_stop;
    $rose(sda_i) && scl_i;
  endsequence
  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain level not zero");
  // Reset itself is the cause here, so it cannot disable the check
  property p_reset_idle;
    disable iff (1'b0) !rst_n_i |=> scl_oe_n_o && sda_oe_n_o && shutdown_pin_n_o && rdata_o == 32'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_shutdown_pin;
    wr_i && addr_i == OFS_CONFIG && wdata_i[CFG_SHUTDOWN_POS] |-> ##2 !shutdown_pin_n_o;
  endproperty
  a_shutdown_pin: assert property (p_shutdown_pin) else $error("shutdown pin not low");
  property p_start_hold;
    $fell(sda_oe_n_o) && scl_i |-> !sda_oe_n_o throughout (##[1:200] !scl_oe_n_o);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not followed by clock low");
  property p_stop_idle;
    s_stop |-> (scl_oe_n_o && sda_oe_n_o) [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus not released after stop");
  property p_clock_count;
    s_stop |-> pulse_q % 8'h09 == 8'h01;
  endproperty
  a_clock_count: assert property (p_clock_count) else $error("clock count not nine per byte");
  property p_addr_msb;
    s_start ##1 s_first_rise |-> !sda_i;
  endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("first address bit not zero");
endmodule

bind pot_host pot_host_checker #(.QUARTER(QUARTER)) u_pot_host_checker (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .shutdown_pin_n_o(shutdown_pin_n_o));

// File: pot_target_model.sv
`timescale 1ns/1ps
module pot_target_model #(
  parameter logic [1:0] STRAP = 2'h0
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic shutdown_pin_n_i,
  output logic sda_oe_n_o,
  output logic [7:0] wiper_channel_first_o,
  output logic [7:0] wiper_channel_second_o,
  output logic logic_out_first_o,
  output logic logic_out_second_o,
  output logic [1:0] off_o
);
  logic [7:0] wiper_code_latch [2];
  logic [7:0] sh_q;
  logic [1:0] shut_q;
  logic sel_q, rd_q, act_q;
  int nb, idx;
  // Power-on state
  initial begin
    wiper_code_latch[0] = 8'h80;
    wiper_code_latch[1] = 8'h80;
    {logic_out_first_o, logic_out_second_o} = 2'b00;
    shut_q = 2'b00;
    sel_q = 1'b0;
    rd_q = 1'b0;
    act_q = 1'b0;
    sda_oe_n_o = 1'b1;
  end
  assign wiper_channel_first_o = wiper_code_latch[0];
  assign wiper_channel_second_o = wiper_code_latch[1];
  // Stored codes untouched; only the switch state follows shutdown
  assign off_o = shut_q | {2{~shutdown_pin_n_i}};
  // Start drops any partial byte; stop ends the transfer
  always @(sda_i) begin
    if (scl_i === 1'b1) begin
      act_q = !sda_i;
      rd_q = 1'b0;
      nb = 0;
      idx = 0;
      sda_oe_n_o = 1'b1;
    end
  end
  // Sample MSB first on rising SCL
  always @(posedge scl_i) begin
    if (act_q) begin
      if (nb < 8) sh_q = {sh_q[6:0], sda_i};
      else if (rd_q && sda_i) act_q = 1'b0;
      nb++;
    end
  end
  // Drive SDA only while SCL is low
  always @(negedge scl_i) begin
    if (act_q) begin
      sda_oe_n_o = 1'b1;
      if (nb == 8 && idx == 0) begin
        act_q = (sh_q[7:1] == {5'h0B, STRAP});
        rd_q = sh_q[0];
        sda_oe_n_o = !act_q;
      end else if (nb == 8 && !rd_q) begin
        sda_oe_n_o = 1'b0;
        if (idx == 1) begin
          sel_q = sh_q[7];
          if (sh_q[6]) wiper_code_latch[sel_q] = 8'h80;
          shut_q[sel_q] = sh_q[5];
          {logic_out_first_o, logic_out_second_o} = sh_q[4:3];
        end else begin
          wiper_code_latch[sel_q] = sh_q;
        end
      end else if (nb == 9) begin
        nb = 0;
        idx++;
        if (rd_q) sh_q = wiper_code_latch[sel_q];
      end
      if (rd_q && nb < 8) sda_oe_n_o = sh_q[7];
    end
  end
endmodule

// File: pot_host_tb_top.sv
`timescale 1ns/1ps
module pot_host_tb_top import pot_host_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic shut_n, scl_oe_n, sda_oe_n, tgt_oe_n, lo_first, lo_second;
  logic [1:0] off;
  logic [7:0] w0, w1;
  logic [31:0] rdata, st;
  wire scl_w, sda_w;
  int failures = 0;
  int checks = 0;
  always #25 clk = ~clk;
  // Pull-ups on both lines; the target never stretches SCL
  assign scl_w = scl_oe_n;
  assign sda_w = sda_oe_n & tgt_oe_n;
  pot_host #(.QUARTER(3)) u_pot_host (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w),
    .sda_o(), .sda_oe_n_o(sda_oe_n), .shutdown_pin_n_o(shut_n));
  pot_target_model #(.STRAP(2'h2)) u_pot_target_model (.scl_i(scl_w), .sda_i(sda_w), .shutdown_pin_n_i(shut_n),
    .sda_oe_n_o(tgt_oe_n), .wiper_channel_first_o(w0), .wiper_channel_second_o(w1),
    .logic_out_first_o(lo_first), .logic_out_second_o(lo_second), .off_o(off));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  // Target side: second wiper, first wiper, two outputs, shutdown state
  task automatic pins(input string nm, input logic [19:0] exp);
    chk(nm, {12'h0, w1, w0, lo_first, lo_second, off}, {12'h0, exp});
  endtask
  // One command; polling is bounded so a stuck engine cannot hang the run
  task automatic run(input logic [3:0] c, input logic [7:0] ins, input logic [7:0] dat, input logic nk);
    int n;
    wr(OFS_INSTR, {24'h0, ins});
    wr(OFS_DATA, {24'h0, dat});
    wr(OFS_CMD, {28'h0, c});
    n = 0;
    st = 32'h0;
    while (st[ST_DONE_POS] !== 1'b1 && n < 3000) begin
      rd(OFS_STATUS, st);
      n++;
    end
    if (n == 3000) failures++;
    chk("nack", {31'h0, st[ST_NACK_POS]}, {31'h0, nk});
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("instr", OFS_INSTR, 32'h00);
    rc("data", OFS_DATA, 32'h80);
    rc("rdata", OFS_RDATA, 32'h80);
    rc("config", OFS_CONFIG, 32'h0);
    rc("status", OFS_STATUS, 32'h0);
    rc("cmd", OFS_CMD, 32'h0);
    rc("unmapped", 8'h18, 32'h0);
    pins("power-on", {8'h80, 8'h80, 4'h0});
    $display("test reset done");
    wr(OFS_CONFIG, 32'h2);
    run(4'h1, 8'h18, 8'h3C, 1'b0);
    pins("write first", {8'h80, 8'h3C, 4'hC});
    run(4'h1, 8'h80, 8'hA5, 1'b0);
    pins("write second", {8'hA5, 8'h3C, 4'h0});
    run(4'h3, 8'h00, 8'h00, 1'b0);
    rc("read second", OFS_RDATA, 32'hA5);
    run(4'h0, 8'h08, 8'h00, 1'b0);
    pins("instr only", {8'hA5, 8'h3C, 4'h4});
    run(4'h3, 8'h00, 8'h00, 1'b0);
    rc("read first", OFS_RDATA, 32'h3C);
    $display("test write read done");
    run(4'h5, 8'h00, 8'h11, 1'b0);
    chk("held", {31'h0, st[ST_HELD_POS]}, 32'h1);
    run(4'h6, 8'h00, 8'h22, 1'b0);
    pins("more data", {8'hA5, 8'h22, 4'h0});
    run(4'h4, 8'h10, 8'h00, 1'b0);
    run(4'h8, 8'h00, 8'h00, 1'b0);
    pins("repeated start", {8'hA5, 8'h22, 4'h8});
    $display("test held write done");
    run(4'h1, 8'h20, 8'h44, 1'b0);
    pins("shutdown", {8'hA5, 8'h44, 4'h1});
    run(4'h0, 8'h00, 8'h00, 1'b0);
    pins("wake", {8'hA5, 8'h44, 4'h0});
    run(4'h0, 8'hC0, 8'h00, 1'b0);
    run(4'h0, 8'h80, 8'h00, 1'b0);
    pins("midscale", {8'h80, 8'h44, 4'h0});
    wr(OFS_CONFIG, 32'h6);
    @(posedge clk);
    pins("pin shutdown", {8'h80, 8'h44, 4'h3});
    wr(OFS_CONFIG, 32'h1);
    run(4'h1, 8'h00, 8'h55, 1'b1);
    pins("other address", {8'h80, 8'h44, 4'h0});
    $display("test shutdown address done");
    // More data without a held write is refused and must not touch the bus
    run(4'h2, 8'h00, 8'h66, 1'b0);
    chk("cmderr", {31'h0, st[ST_CMDERR_POS]}, 32'h1);
    run(4'h8, 8'h00, 8'h00, 1'b0);
    chk("cmderr clear", {31'h0, st[ST_CMDERR_POS]}, 32'h0);
    pins("refused more", {8'h80, 8'h44, 4'h0});
    $display("test command errors done");
    results();
  end
endmodule
